// ===== bench/testbench.sv
// self-checking bench for the main clock and time-base controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import mct_pkg::*;
	// shortened periods keep the run brief
	localparam int PER [4] = '{200, 400, 1000, 2500};
	localparam logic [9:0] A_MISC = {MCT_IDX_MISC1, 2'b00};
	localparam logic [9:0] A_CS   = {MCT_IDX_RTCCS, 2'b00};
	localparam logic [9:0] A_IST  = {MCT_IDX_ISTAT, 2'b00};
	localparam logic [9:0] A_IMK  = {MCT_IDX_IMASK, 2'b00};
	logic        mclk_in, reset_n_in, clk_en_in, wb_cyc_in, wb_stb_in, wb_we_in;
	logic [9:0]  wb_adr_in;
	logic [3:0]  wb_sel_in;
	logic [31:0] wb_dat_in, wb_dat_out;
	logic        wb_ack_out, halt_req_in, ext_wake_in, wait_in, cpu_irq_mask_in;
	logic        cpu_clk_en_out, can_clk_en_out, clk_out_o_out, clk_out_oe_out;
	logic        standby_out, halt_out, timer_irq_req_out, wait_wake_out, irq_out;
	logic [2:0]  mon;
	logic [7:0]  q;
	logic        v;
	int          errors, comparisons, cyc_n, t0, t1, t2, t3, prv;
	mct_ctrl #(.TB_P0(PER[0]), .TB_P1(PER[1]), .TB_P2(PER[2]), .TB_P3(PER[3])) DUT (
		.mclk_in, .reset_n_in, .clk_en_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
		.wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .halt_req_in, .ext_wake_in,
		.wait_in, .cpu_irq_mask_in, .cpu_clk_en_out, .can_clk_en_out, .clk_out_o_out,
		.clk_out_oe_out, .standby_out, .halt_out, .timer_irq_req_out, .wait_wake_out,
		.irq_out);
	// monitored one-cycle strobes
	assign mon = {can_clk_en_out, cpu_clk_en_out, wait_wake_out};
	// clock and free cycle count for interval timing
	initial begin
		mclk_in = 1'b0;
		forever #2 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) cyc_n <= cyc_n + 1;
	task automatic summarize;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : chk
	// one classic cycle; waits for ack with no assumed latency
	task automatic wb(input logic we, input logic [9:0] a, input logic [7:0] d);
		int n;
		n = 0;
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in  <= we;
		wb_adr_in <= a;
		wb_dat_in <= {24'h0, d};
		do begin
			@(posedge mclk_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 50);
		q = wb_dat_out[7:0];
		if (n >= 50) chk(1'b0, 1'b1, "bus ack timeout");
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		@(posedge mclk_in);
	endtask : wb
	// wait for strobe k, returning the cycle stamp
	task automatic tk(input int k, output int t);
		int n;
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
		end while (mon[k] !== 1'b1 && n < 3000);
		t = cyc_n;
		if (n >= 3000) chk(1'b0, 1'b1, "strobe timeout");
	endtask : tk
	// watchdog well beyond the planned length
	initial begin
		repeat (60000) @(posedge mclk_in);
		errors++;
		summarize();
	end
	initial begin
		{wb_cyc_in, wb_stb_in, wb_we_in, halt_req_in, ext_wake_in, cpu_irq_mask_in} = '0;
		{wb_adr_in, wb_dat_in, errors, comparisons, cyc_n} = '0;
		wb_sel_in = 4'hf;
		clk_en_in = 1'b1;
		wait_in = 1'b0;
		reset_n_in = 1'b0;
		repeat (3) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		// reset values, access kinds, unmapped place
		wb(0, A_CS, 8'h00); chk(q, 8'h01, "status reset");
		wb(0, A_CS, 8'h00); chk(q, 8'h00, "flag clear on read");
		wb(0, A_MISC, 8'h00); chk(q, 8'h00, "misc reset");
		wb(0, A_IMK, 8'h00); chk(q, 8'h00, "mask reset");
		wb(0, 10'h3fc, 8'h00); chk(q, 8'h00, "unmapped read");
		wb(1, A_CS, 8'hff); wb(0, A_CS, 8'h00); chk(q & 8'hfe, 8'h0e, "status bits");
		wb(1, A_MISC, 8'hff); wb(0, A_MISC, 8'h00); chk(q, 8'h27, "misc bits");
		// a write without byte lane 0 must leave the register alone
		wb_sel_in <= 4'h0;
		wb(1, A_MISC, 8'h00);
		wb_sel_in <= 4'hf;
		wb(0, A_MISC, 8'h00); chk(q, 8'h27, "lane 0 off ignored");
		$display("test registers done");
		// time-base periods and deferred select change
		wait_in <= 1'b1;
		wb(1, A_CS, 8'h02); // whole-byte write, never a bit set or clear
		tk(0, t0); tk(0, t1); chk(t1 - t0, PER[0], "period 0");
		prv = 0;
		for (int s = 1; s < 5; s++) begin
			wb(1, A_CS, {4'h0, 2'(s % 4), 2'b10});
			tk(0, t2); chk(t2 - t1, PER[prv], "old period kept");
			tk(0, t3); chk(t3 - t2, PER[s % 4], "new period");
			t1 = t3;
			prv = s % 4;
		end
		$display("test time base done");
		// timer request, cpu mask, flag, interrupt unit
		wb(1, A_IMK, 8'h01); wb(0, A_IST, 8'h00); wb(0, A_CS, 8'h00);
		tk(0, t0); repeat (2) @(posedge mclk_in);
		chk(timer_irq_req_out, 1'b1, "timer request");
		chk(irq_out, 1'b1, "irq raised");
		cpu_irq_mask_in <= 1'b1;
		repeat (2) @(posedge mclk_in);
		chk(timer_irq_req_out, 1'b0, "cpu mask blocks");
		cpu_irq_mask_in <= 1'b0;
		wb(0, A_CS, 8'h00); chk(q, 8'h03, "flag set");
		chk(timer_irq_req_out, 1'b0, "request after read");
		wb(0, A_IST, 8'h00); chk(q, 8'h01, "status event");
		@(posedge mclk_in); chk(irq_out, 1'b0, "irq cleared");
		wb(1, A_IMK, 8'h00); tk(0, t0); repeat (2) @(posedge mclk_in);
		chk(irq_out, 1'b0, "irq masked");
		wb(0, A_IST, 8'h00); chk(q, 8'h01, "masked status kept");
		$display("test interrupts done");
		// prescaler ratios and the CAN clock
		for (int k = 0; k < 5; k++) begin
			wb(1, A_MISC, (k == 0) ? 8'h00 : {5'h0, 2'(k - 1), 1'b1});
			tk(1, t0); tk(1, t1); tk(1, t2);
			chk(t2 - t1, (k == 0) ? 2 : (4 << (k - 1)), "cpu ratio");
			tk(2, t0); tk(2, t1); chk(t1 - t0, 2, "can ratio");
		end
		$display("test prescaler done");
		// clock-out, standby, full halt
		// align to a period end so standby entry cannot race a wake event
		tk(0, t0);
		wait_in <= 1'b0;
		wb(1, A_MISC, 8'h20); wb(1, A_CS, 8'h02);
		chk(clk_out_oe_out, 1'b1, "clock-out enable");
		for (int i = 0; i < 4; i++) begin
			v = clk_out_o_out;
			@(posedge mclk_in); chk(clk_out_o_out, !v, "clock-out toggles");
		end
		halt_req_in <= 1'b1;
		@(posedge mclk_in);
		halt_req_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		chk(standby_out, 1'b1, "standby entered");
		v = clk_out_o_out;
		repeat (5) @(posedge mclk_in);
		chk(clk_out_o_out, v, "clock-out held");
		wb(1, A_CS, 8'h00); // frozen in standby, acked but dropped
		for (int n = 0; n < 300 && standby_out === 1'b1; n++) @(posedge mclk_in);
		chk(standby_out, 1'b0, "standby wake");
		wb(0, A_CS, 8'h00); chk(q, 8'h03, "standby write ignored");
		wb(0, A_IST, 8'h00); chk(q, 8'h03, "wake event");
		wb(1, A_CS, 8'h00);
		halt_req_in <= 1'b1;
		@(posedge mclk_in);
		halt_req_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		chk(halt_out, 1'b1, "halt entered");
		repeat (600) @(posedge mclk_in);
		chk(halt_out, 1'b1, "halt not woken by timer");
		ext_wake_in <= 1'b1;
		@(posedge mclk_in);
		ext_wake_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		chk(halt_out, 1'b0, "halt exit");
		$display("test power modes done");
		// clock enable low freezes the pin and the derived ticks
		clk_en_in <= 1'b0;
		@(posedge mclk_in);
		v = clk_out_o_out;
		repeat (3) @(posedge mclk_in);
		chk(clk_out_o_out, v, "freeze holds clock-out");
		chk(can_clk_en_out, 1'b0, "freeze stops ticks");
		clk_en_in <= 1'b1;
		$display("test clock enable done");
		summarize();
	end
endmodule : testbench
`default_nettype wire

// ===== src/mct_ctrl.sv
// main clock controller with time-base timer, wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module mct_ctrl #(
	parameter int TB_P0 = mct_pkg::MCT_TB_P0,
	parameter int TB_P1 = mct_pkg::MCT_TB_P1,
	parameter int TB_P2 = mct_pkg::MCT_TB_P2,
	parameter int TB_P3 = mct_pkg::MCT_TB_P3
) (
	// oscillator clock, reset, freeze
	input  wire logic        mclk_in,
	input  wire logic        reset_n_in,
	input  wire logic        clk_en_in,
	// wishbone slave
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [9:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	// cpu power and interrupt side
	input  wire logic        halt_req_in,
	input  wire logic        ext_wake_in,
	input  wire logic        wait_in,
	input  wire logic        cpu_irq_mask_in,
	// derived clocks
	output logic             cpu_clk_en_out,
	output logic             can_clk_en_out,
	output logic             clk_out_o_out,
	output logic             clk_out_oe_out,
	// state and interrupts
	output logic             standby_out,
	output logic             halt_out,
	output logic             timer_irq_req_out,
	output logic             wait_wake_out,
	output logic             irq_out
);
	import mct_pkg::*;

	mct_tb_if tb_if ();

	// software visible state
	logic [1:0]  time_base_select_r;
	logic        timer_irq_enable_r;
	logic        timer_irq_flag_r;
	logic [1:0]  prescale_select_r;
	logic        slow_mode_select_r;
	logic        clock_out_enable_r;
	logic [1:0]  irq_stat_r;
	logic [1:0]  irq_mask_r;
	// internal state
	mct_mode_t   mode_r;
	logic        ack_r;
	logic [31:0] dat_r;
	logic        clk_pin_r;
	logic        wait_wake_r;
	// decode and events
	logic        req_w;
	logic [7:0]  idx_w;
	logic        frozen_w;
	logic        wr_w;
	logic        rd_w;
	logic [7:0]  rd_data_w;
	logic        tb_evt_w;
	logic        wake_evt_w;
	logic [5:0]  cpu_ratio_w;

	// request is taken once; ack drops the cycle after it is given
	assign req_w = wb_cyc_in && wb_stb_in && !ack_r;
	assign idx_w = wb_adr_in[9:2];

	// registers freeze in either halt flavour
	assign frozen_w = (mode_r != MCT_RUN);

	// only byte lane 0 carries register data
	assign wr_w = req_w && wb_we_in && wb_sel_in[0] && !frozen_w;
	assign rd_w = req_w && !wb_we_in && !frozen_w;

	// time-base event, counter stands still in full halt
	assign tb_evt_w   = tb_if.tick && (mode_r != MCT_HALT);
	assign wake_evt_w = tb_evt_w && (mode_r == MCT_STANDBY);

	// read data; reserved bits and unmapped indices read as zero
	always_comb begin
		rd_data_w = 8'h00;
		unique case (idx_w)
			MCT_IDX_RTCCS: begin
				rd_data_w = {4'h0, time_base_select_r,
					timer_irq_enable_r, timer_irq_flag_r};
			end
			MCT_IDX_MISC1: begin
				rd_data_w[MCT_M1_SMS]          = slow_mode_select_r;
				rd_data_w[MCT_M1_CP+:2]        = prescale_select_r;
				rd_data_w[MCT_M1_MCO]          = clock_out_enable_r;
			end
			MCT_IDX_ISTAT: begin
				rd_data_w[1:0] = irq_stat_r;
			end
			MCT_IDX_IMASK: begin
				rd_data_w[1:0] = irq_mask_r;
			end
			default: begin
				rd_data_w = 8'h00;
			end
		endcase
	end

	// bus answer: one cycle after the request, with registered data
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else if (clk_en_in) begin
			ack_r <= req_w;
			if (req_w && !wb_we_in)
				dat_r <= {24'h00_0000, rd_data_w};
		end
	end

	// time base control fields; frozen writes are acked but dropped
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			time_base_select_r <= MCT_RTCCS_RST[MCT_CS_TB+:2];
			timer_irq_enable_r <= MCT_RTCCS_RST[MCT_CS_IE];
		end else if (clk_en_in && wr_w && idx_w == MCT_IDX_RTCCS) begin
			time_base_select_r <= wb_dat_in[MCT_CS_TB+:2];
			timer_irq_enable_r <= wb_dat_in[MCT_CS_IE];
		end
	end

	// timer flag: hardware set wins over the read clear in the same cycle
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			timer_irq_flag_r <= MCT_RTCCS_RST[MCT_CS_FLAG];
		end else if (clk_en_in) begin
			if (tb_evt_w)
				timer_irq_flag_r <= 1'b1;
			else if (rd_w && idx_w == MCT_IDX_RTCCS)
				timer_irq_flag_r <= 1'b0;
		end
	end

	// prescaler and clock-out control; writes to the reserved bits are ignored
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			slow_mode_select_r <= 1'b0;
			prescale_select_r  <= 2'b00;
			clock_out_enable_r <= 1'b0;
		end else if (clk_en_in && wr_w && idx_w == MCT_IDX_MISC1) begin
			slow_mode_select_r <= wb_dat_in[MCT_M1_SMS];
			prescale_select_r  <= wb_dat_in[MCT_M1_CP+:2];
			clock_out_enable_r <= wb_dat_in[MCT_M1_MCO];
		end
	end

	// sticky event bits, cleared by reading them; set wins
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_stat_r <= MCT_IRQ_RST;
		end else if (clk_en_in) begin
			if (rd_w && idx_w == MCT_IDX_ISTAT)
				irq_stat_r <= 2'b00;
			if (tb_evt_w)
				irq_stat_r[MCT_IRQ_TB] <= 1'b1;
			if (wake_evt_w)
				irq_stat_r[MCT_IRQ_WK] <= 1'b1;
		end
	end

	// interrupt mask
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			irq_mask_r <= MCT_IRQ_RST;
		else if (clk_en_in && wr_w && idx_w == MCT_IDX_IMASK)
			irq_mask_r <= wb_dat_in[1:0];
	end

	// power mode: halt picks standby when the timer interrupt is enabled
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mode_r <= MCT_RUN;
		end else if (clk_en_in) begin
			unique case (mode_r)
				MCT_RUN: begin
					if (halt_req_in)
						mode_r <= timer_irq_enable_r ? MCT_STANDBY : MCT_HALT;
				end
				MCT_STANDBY: begin
					if (tb_evt_w)
						mode_r <= MCT_RUN;
				end
				MCT_HALT: begin
					if (ext_wake_in)
						mode_r <= MCT_RUN;
				end
				default: begin
					mode_r <= MCT_RUN;
				end
			endcase
		end
	end

	// wait is the cpu's business; the timer simply keeps going and wakes it
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			wait_wake_r <= 1'b0;
		else if (clk_en_in)
			wait_wake_r <= wait_in && tb_evt_w && timer_irq_enable_r;
		else
			wait_wake_r <= 1'b0;
	end

	// clock-out pin toggles every cycle, only in run since osc stops in halt
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			clk_pin_r <= 1'b0;
		else if (clk_en_in) begin
			if (!clock_out_enable_r)
				clk_pin_r <= 1'b0;
			else if (mode_r == MCT_RUN)
				clk_pin_r <= !clk_pin_r;
		end
	end

	// cpu ratio: two in fast mode, 4 shifted by the select in slow mode
	assign cpu_ratio_w = slow_mode_select_r ? (MCT_DIV_SLOW << prescale_select_r)
		: MCT_DIV_FAST;

	// cpu clock stops with the core in either halt flavour
	mct_div u_cpu_div (
		.clk_in     (mclk_in),
		.reset_n_in (reset_n_in),
		.en_in      (clk_en_in && mode_r == MCT_RUN),
		.ratio_in   (cpu_ratio_w),
		.tick_out   (cpu_clk_en_out)
	);

	// can clock bypasses the prescaler entirely
	mct_div u_can_div (
		.clk_in     (mclk_in),
		.reset_n_in (reset_n_in),
		.en_in      (clk_en_in),
		.ratio_in   (MCT_DIV_CAN),
		.tick_out   (can_clk_en_out)
	);

	// time base runs in run, wait and standby, each unit on its own
	assign tb_if.sel = time_base_select_r;
	assign tb_if.run = (mode_r != MCT_HALT);

	mct_timebase #(
		.P0 (TB_P0),
		.P1 (TB_P1),
		.P2 (TB_P2),
		.P3 (TB_P3)
	) u_timebase (
		.clk_in     (mclk_in),
		.reset_n_in (reset_n_in),
		.en_in      (clk_en_in),
		.tb         (tb_if.cnt)
	);

	// outputs
	assign wb_ack_out        = ack_r;
	assign wb_dat_out        = dat_r;
	assign clk_out_o_out     = clk_pin_r;
	assign clk_out_oe_out    = clock_out_enable_r;
	assign standby_out       = (mode_r == MCT_STANDBY);
	assign halt_out          = (mode_r == MCT_HALT);
	// level request, the cpu mask gates it here so the core sees one line
	assign timer_irq_req_out = timer_irq_flag_r && timer_irq_enable_r
		&& !cpu_irq_mask_in;
	assign wait_wake_out     = wait_wake_r;
	assign irq_out           = |(irq_stat_r & irq_mask_r);

	// checks
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!reset_n_in);

	flag_set_a: assert property (
		clk_en_in && tb_if.tick && mode_r != MCT_HALT |=> timer_irq_flag_r)
		else $error("period end did not set the timer flag");

	flag_read_clear_a: assert property (
		clk_en_in && rd_w && idx_w == MCT_IDX_RTCCS && !tb_if.tick
		|=> !timer_irq_flag_r)
		else $error("status read did not clear the timer flag");

	irq_request_a: assert property (
		clk_en_in && tb_if.tick && mode_r != MCT_HALT && timer_irq_enable_r
		|=> timer_irq_req_out || cpu_irq_mask_in || !timer_irq_enable_r)
		else $error("period end without an interrupt request");

	reserved_zero_a: assert property (
		wb_ack_out && $past(idx_w) == MCT_IDX_RTCCS && $past(clk_en_in)
		&& !$past(wb_we_in) |-> wb_dat_out[31:4] == 28'h000_0000)
		else $error("reserved status bits read nonzero");

	standby_entry_a: assert property (
		clk_en_in && mode_r == MCT_RUN && halt_req_in && timer_irq_enable_r
		|=> mode_r == MCT_STANDBY)
		else $error("halt with enable did not enter standby");

	halt_hold_a: assert property (
		clk_en_in && mode_r == MCT_HALT && !ext_wake_in
		|=> mode_r == MCT_HALT && $stable(timer_irq_flag_r))
		else $error("full halt left or flag moved without wake");

	standby_wake_a: assert property (
		clk_en_in && mode_r == MCT_STANDBY && tb_if.tick
		|=> mode_r == MCT_RUN && timer_irq_flag_r)
		else $error("time-base event did not wake standby");

	clkout_stop_a: assert property (
		mode_r == MCT_STANDBY && clock_out_enable_r |=> $stable(clk_pin_r))
		else $error("clock-out toggled in standby");

	clkout_toggle_a: assert property (
		clk_en_in && clock_out_enable_r && mode_r == MCT_RUN
		|=> clk_pin_r != $past(clk_pin_r))
		else $error("clock-out not at half the oscillator rate");

	// ack only falls on an enabled edge, so a frozen cycle may stretch it
	ack_single_a: assert property (
		wb_ack_out && clk_en_in |=> !wb_ack_out)
		else $error("ack held longer than one cycle");

	can_half_rate_a: assert property (
		clk_en_in && can_clk_en_out ##1 clk_en_in
		|-> !can_clk_en_out ##1 can_clk_en_out)
		else $error("can clock not at half the oscillator rate");

	wait_wake_a: assert property (
		clk_en_in && wait_in && tb_if.tick && mode_r != MCT_HALT && timer_irq_enable_r
		|=> wait_wake_out)
		else $error("time-base event did not end the wait");

	freeze_hold_a: assert property (
		!clk_en_in |=> $stable(mode_r) && $stable(timer_irq_flag_r) && $stable(clk_pin_r))
		else $error("state moved while the clock enable was low");
endmodule : mct_ctrl
`default_nettype wire

// ===== src/mct_div.sv
// programmable divider giving one tick per ratio cycles
`timescale 1ns/1ps
`default_nettype none
module mct_div (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       reset_n_in,
	input  wire logic       en_in,
	// ratio and tick
	input  wire logic [5:0] ratio_in,
	output logic            tick_out
);
	logic [5:0] cnt_r;
	logic       tick_r;

	// count down, reload at zero; a new ratio lands at the next reload
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_r  <= 6'h00;
			tick_r <= 1'b0;
		end else if (en_in) begin
			tick_r <= (cnt_r == 6'h00);
			if (cnt_r == 6'h00)
				cnt_r <= ratio_in - 6'h01;
			else
				cnt_r <= cnt_r - 6'h01;
		end else begin
			tick_r <= 1'b0;
		end
	end

	assign tick_out = tick_r;
endmodule : mct_div
`default_nettype wire

// ===== src/mct_pkg.sv
// constants and types of the main clock and time-base controller
`default_nettype none
// Behaviour
// - prescaler, clock-out and time-base timer run independently and may all be active at once.
// - the cpu clock is the oscillator divided by a ratio set by prescale_select and slow_mode_select.
// - the CAN clock is always the oscillator divided by two, whatever the prescaler says.
// - with clock_out_enable set, the clock-out pin carries the oscillator divided by two.
// - in clocked standby the clock-out pin stops toggling.
// - time_base_select gives periods of 32000, 64000, 160000 or 400000 oscillator cycles.
// - a new time_base_select takes effect only when the running period ends.
// - each period end sets timer_irq_flag.
// - a software read of rtc_control_status clears timer_irq_flag.
// - a timer interrupt is requested when the flag and enable are set and the cpu mask is off.
// - halt with timer_irq_enable set enters clocked standby instead of full halt.
// - in clocked standby the counter runs, registers freeze, and a time-base event wakes the part.
// - in full halt counter and registers freeze; only another wake source resumes counting.
// - in wait mode the timer runs on and its interrupt ends the wait.
// - rtc_control_status reads 0 in bits 7:4, select in 3:2, enable in 1, flag in 0, reset 01h.
package mct_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] MCT_IDX_MISC1 = 8'h20;
	localparam logic [7:0] MCT_IDX_RTCCS = 8'h29;
	localparam logic [7:0] MCT_IDX_ISTAT = 8'h30;
	localparam logic [7:0] MCT_IDX_IMASK = 8'h31;
	// reset values
	localparam logic [7:0] MCT_RTCCS_RST = 8'h01;
	localparam logic [1:0] MCT_IRQ_RST   = 2'h0;
	// field positions
	localparam int MCT_CS_FLAG = 0;
	localparam int MCT_CS_IE   = 1;
	localparam int MCT_CS_TB   = 2;
	localparam int MCT_M1_SMS  = 0;
	localparam int MCT_M1_CP   = 1;
	localparam int MCT_M1_MCO  = 5;
	localparam int MCT_IRQ_TB  = 0;
	localparam int MCT_IRQ_WK  = 1;
	// clock ratios in oscillator cycles
	localparam logic [5:0] MCT_DIV_FAST = 6'h02;
	localparam logic [5:0] MCT_DIV_SLOW = 6'h04;
	localparam logic [5:0] MCT_DIV_CAN  = 6'h02;
	// time-base periods in oscillator cycles
	localparam int MCT_TB_P0 = 32000;
	localparam int MCT_TB_P1 = 64000;
	localparam int MCT_TB_P2 = 160000;
	localparam int MCT_TB_P3 = 400000;
	localparam int MCT_TB_W  = 19;
	// power modes
	typedef enum logic [1:0] {
		MCT_RUN,
		MCT_STANDBY,
		MCT_HALT
	} mct_mode_t;
endpackage : mct_pkg
`default_nettype wire

// ===== src/mct_tb_if.sv
// interface between the controller core and its time-base counter
`timescale 1ns/1ps
`default_nettype none
interface mct_tb_if;
	logic [1:0] sel;
	logic       run;
	logic       tick;
	modport ctl (output sel, output run, input tick);
	modport cnt (input sel, input run, output tick);
endinterface : mct_tb_if
`default_nettype wire

// ===== src/mct_timebase.sv
// time-base counter with select latched at each period end
`timescale 1ns/1ps
`default_nettype none
module mct_timebase #(
	parameter int P0 = mct_pkg::MCT_TB_P0,
	parameter int P1 = mct_pkg::MCT_TB_P1,
	parameter int P2 = mct_pkg::MCT_TB_P2,
	parameter int P3 = mct_pkg::MCT_TB_P3
) (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic reset_n_in,
	input  wire logic en_in,
	// control and tick
	mct_tb_if.cnt     tb
);
	import mct_pkg::*;
	logic [MCT_TB_W-1:0] cnt_r;
	logic [MCT_TB_W-1:0] last_w;
	logic [1:0]          act_sel_r;
	logic                tick_r;

	// last count of the period in force
	always_comb begin
		unique case (act_sel_r)
			2'b00: last_w = MCT_TB_W'(P0 - 1);
			2'b01: last_w = MCT_TB_W'(P1 - 1);
			2'b10: last_w = MCT_TB_W'(P2 - 1);
			2'b11: last_w = MCT_TB_W'(P3 - 1);
		endcase
	end

	// period counter; select sampled only at the wrap so no time shift occurs
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_r     <= '0;
			act_sel_r <= 2'b00;
			tick_r    <= 1'b0;
		end else if (en_in) begin
			tick_r <= 1'b0;
			if (tb.run) begin
				if (cnt_r == last_w) begin
					cnt_r     <= '0;
					tick_r    <= 1'b1;
					act_sel_r <= tb.sel;
				end else begin
					cnt_r <= cnt_r + 1'b1;
				end
			end
		end
	end

	assign tb.tick = tick_r;
endmodule : mct_timebase
`default_nettype wire
